// ===== testbench/reg_host_model.sv
// host model: single-cycle register strobes and read data collection
module reg_host_model (
    input wire logic clk,
    output logic [6:0] addr,
    output logic wr,
    output logic [7:0] wdata,
    output logic rd,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 7'h00;
        wr = 1'b0;
        wdata = 8'h00;
        rd = 1'b0;
    end
    // idle cycles after every access keep tag reads apart; read data taken once settled
    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
        @(posedge clk);
    endtask
    task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        repeat (2) @(posedge clk);
        d = rdata;
    endtask
endmodule // reg_host_model

// ===== testbench/sensor_batching_fifo_asserts.sv
// concurrent checks of the batching buffer register port and interrupt pins
`include "batch_fifo_map.vh"

module sensor_batching_fifo_asserts (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic [6:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic INTERRUPT_PIN_ONE,
    input wire logic INTERRUPT_PIN_TWO
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wm_low;
    logic [7:0] wm_high;
    logic [2:0] mode;
    logic [7:0] route_one;
    logic [7:0] route_two;
    logic [2:0] bypass_age;
    wire [8:0] wm = {wm_high[`FB_WMH_LEVEL_MSB], wm_low};

    // shadow copies, updated on the same edge as the control registers
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wm_low <= 8'h00;
            wm_high <= 8'h00;
            mode <= 3'h0;
            route_one <= 8'h00;
            route_two <= 8'h00;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `FB_ADDR_WM_LOW: wm_low <= REG_WDATA;
                `FB_ADDR_WM_HIGH: wm_high <= REG_WDATA;
                `FB_ADDR_MODE: mode <= REG_WDATA[2:0];
                `FB_ADDR_PIN_ONE: route_one <= REG_WDATA;
                `FB_ADDR_PIN_TWO: route_two <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // the flush takes a few edges, so bypass is judged only once settled
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B)
            bypass_age <= 3'h0;
        else if (mode != `FB_MODE_BYPASS)
            bypass_age <= 3'h0;
        else if (bypass_age != 3'h7)
            bypass_age <= bypass_age + 3'h1;
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_read(logic [6:0] a);
        REG_RD && REG_ADDR == a;
    endsequence
    sequence s_settled_read(logic [6:0] a);
        bypass_age >= 3'h3 && REG_RD && REG_ADDR == a;
    endsequence

    a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (REG_RD && REG_ADDR < `FB_ADDR_EXT_CTRL
        |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_bypass_count: assert property (s_settled_read(`FB_ADDR_STAT_LOW) |=> REG_RDATA == 8'h00)
        else $error("count not zero in bypass");
    a_bypass_tag: assert property (s_settled_read(`FB_ADDR_TAG) |=> REG_RDATA == 8'h00)
        else $error("tag read in bypass not zero");
    a_bypass_empty: assert property (s_settled_read(`FB_ADDR_STAT_HIGH)
        |=> REG_RDATA[`FB_ST_EMPTY] && REG_RDATA[1:0] == 2'b00)
        else $error("empty not shown in bypass");
    a_below_wm_clear: assert property ((wm != 9'h000) ##0 s_settled_read(`FB_ADDR_STAT_HIGH)
        |=> !REG_RDATA[`FB_ST_WM])
        else $error("watermark flag with empty buffer");
    a_zero_wm_flag: assert property ((wm == 9'h000) ##0 s_read(`FB_ADDR_STAT_HIGH)
        |=> REG_RDATA[`FB_ST_WM])
        else $error("watermark flag low at level zero");
    a_pin_one_quiet: assert property (!route_one[`FB_PIN_WM_ROUTE]
        && !route_one[`FB_PIN_FULL_ROUTE] |-> !INTERRUPT_PIN_ONE)
        else $error("pin one high with no route");
    a_pin_one_wm: assert property ((route_one[`FB_PIN_WM_ROUTE] && wm == 9'h000)[*3]
        |-> INTERRUPT_PIN_ONE)
        else $error("pin one misses watermark");
    a_pin_two_full: assert property ((route_two[`FB_PIN_FULL_ROUTE] && wm_high[`FB_WMH_STOP_WM]
        && wm == 9'h000)[*3] |-> INTERRUPT_PIN_TWO)
        else $error("pin two misses full");
endmodule // sensor_batching_fifo_asserts

bind sensor_batching_fifo sensor_batching_fifo_asserts chk_i (
    .SYS_CLK(SYS_CLK),
    .RST_B(RST_B),
    .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .INTERRUPT_PIN_ONE(INTERRUPT_PIN_ONE),
    .INTERRUPT_PIN_TWO(INTERRUPT_PIN_TWO)
);

// ===== testbench/sensor_batching_fifo_tb.sv
// self-checking bench of the sensor batching buffer
`include "batch_fifo_map.vh"

module sensor_batching_fifo_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WM = 5;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic acc_drdy = 1'b0;
    logic gyro_drdy = 1'b0;
    logic temp_drdy = 1'b0;
    logic rate_change = 1'b0;
    logic step_det = 1'b0;
    logic [47:0] acc_data = 48'h0;
    logic [47:0] gyro_data = 48'h0;
    logic [15:0] temp_data = 16'h0;
    logic [7:0] rate_code = 8'h00;
    logic [31:0] timestamp = 32'h0;
    logic [4:0] trig = 5'h00;
    logic stall_b;
    logic pin_one;
    logic pin_two;
    logic [31:0] seed = 32'h43d7;
    logic [47:0] words[8];
    logic [2:0] modes[8] = '{3'h1, 3'h6, 3'h3, 3'h3, 3'h4, 3'h4, 3'h7, 3'h7};
    logic [6:0] zero_addr[9] = '{7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0d, 7'h0e, 7'h3a, 7'h00};
    logic [7:0] burst_tags[5] = '{`FB_TAG_GYRO, `FB_TAG_ACC, `FB_TAG_TEMP, `FB_TAG_STEP,
        `FB_TAG_CFG};
    int errors = 0;
    int checks = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) timestamp <= timestamp + 32'h1;

    reg_host_model host (.clk(clk), .addr(reg_addr), .wr(reg_wr), .wdata(reg_wdata),
        .rd(reg_rd), .rdata(reg_rdata));

    sensor_batching_fifo uut (.SYS_CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .ACC_DRDY(acc_drdy), .ACC_DATA(acc_data), .GYRO_DRDY(gyro_drdy),
        .GYRO_DATA(gyro_data), .TEMP_DRDY(temp_drdy), .TEMP_DATA(temp_data),
        .HUB_DRDY(1'b0), .EXT_DATA({192{1'b0}}), .STEP_DET(step_det), .STEP_COUNT(16'h0000),
        .TIMESTAMP(timestamp), .OUTPUT_RATE_CHANGE(rate_change), .OUTPUT_RATE_CODE(rate_code),
        .TRIGGER_EVENTS(trig), .SENSOR_STALL_B(stall_b), .INTERRUPT_PIN_ONE(pin_one),
        .INTERRUPT_PIN_TWO(pin_two));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // 0 drops everything, 1 stops when full, 2 overwrites the oldest
    function automatic int eff(input logic [2:0] m, input logic t);
        case (m)
            `FB_MODE_STOP: eff = 1;
            `FB_MODE_CONT: eff = 2;
            `FB_MODE_CONT_STOP: eff = t ? 1 : 2;
            `FB_MODE_BYP_CONT: eff = t ? 2 : 0;
            `FB_MODE_BYP_STOP: eff = t ? 1 : 0;
            default: eff = 0;
        endcase
    endfunction

    // stop-at-watermark is on, so the full limit equals the watermark level
    function automatic logic [7:0] stat_hi(input int c, input logic ovr);
        stat_hi = {c >= WM, ovr, c >= WM, c == 0, 4'h0};
    endfunction

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] v);
        checks++;
        if (v !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, v);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string what);
        logic [7:0] v;
        host.reg_read(a, v);
        chk(what, e, v);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        int r;
        int n;
        int e;
        int c;
        int first;
        logic [63:0] w;
        logic [2:0] sel;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (r = 0; r < 9; r++)
            rd_chk(zero_addr[r], 8'h00, "reset value");
        rd_chk(`FB_ADDR_STAT_HIGH, 8'h90, "reset status");
        // unit rates for every sensor, timestamp words off so counts stay exact
        host.reg_write(`FB_ADDR_RATE, 8'hd5);
        rd_chk(`FB_ADDR_RATE, 8'hd5, "rate");
        host.reg_write(`FB_ADDR_PIN_ONE, 8'h08);
        host.reg_write(`FB_ADDR_PIN_TWO, 8'h20);
        host.reg_write(`FB_ADDR_WM_HIGH, 8'h80);
        repeat (3) @(posedge clk);
        chk("pin one", 8'h01, {7'h00, pin_one});
        chk("pin two", 8'h01, {7'h00, pin_two});
        w = {32'h0, rnd()};
        host.reg_write(`FB_ADDR_WM_LOW, w[7:0]);
        rd_chk(`FB_ADDR_WM_LOW, w[7:0], "watermark");
        host.reg_write(`FB_ADDR_WM_LOW, 8'(WM));
        for (r = 0; r < 8; r++) begin
            host.reg_write(`FB_ADDR_MODE, 8'h00);
            repeat (3) @(posedge clk);
            rd_chk(`FB_ADDR_STAT_LOW, 8'h00, "count after clear");
            rd_chk(`FB_ADDR_TAG, 8'h00, "tag in bypass");
            rd_chk(`FB_ADDR_STAT_HIGH, 8'h10, "status after clear");
            sel = 3'(r % 5);
            trig <= r[0] ? (5'h01 << sel) : ~(5'h01 << sel);
            host.reg_write(`FB_ADDR_MODE, {1'b0, sel, 1'b0, modes[r]});
            n = 3 + int'(rnd() % 6);
            for (int i = 0; i < n; i++) begin
                w = {rnd(), rnd()};
                words[i] = w[47:0];
                acc_data <= w[47:0];
                acc_drdy <= 1'b1;
                @(posedge clk);
                acc_drdy <= 1'b0;
                repeat (3) @(posedge clk);
            end
            e = eff(modes[r], r[0]);
            c = (e == 0) ? 0 : (n < WM ? n : WM);
            first = (e == 2) ? n - c : 0;
            rd_chk(`FB_ADDR_STAT_LOW, 8'(c), "count");
            rd_chk(`FB_ADDR_STAT_HIGH, stat_hi(c, e == 2 && n > WM), "status");
            chk("pin one", {7'h00, c >= WM}, {7'h00, pin_one});
            chk("pin two", {7'h00, c >= WM}, {7'h00, pin_two});
            if (c > 0) begin
                rd_chk(`FB_ADDR_TAG, `FB_TAG_ACC, "tag");
                for (int b = 0; b < 6; b++)
                    rd_chk(7'(`FB_ADDR_DATA_FIRST + b), words[first][8*b +: 8], "data");
                rd_chk(`FB_ADDR_STAT_HIGH, stat_hi(c - 1, 1'b0), "status after pop");
            end
        end
        // five sources in one cycle press on the two-entry buffer
        host.reg_write(`FB_ADDR_MODE, 8'h00);
        host.reg_write(`FB_ADDR_WM_HIGH, 8'h90);
        host.reg_write(`FB_ADDR_EXT_CTRL, 8'h10);
        host.reg_write(`FB_ADDR_MODE, {5'h00, `FB_MODE_STOP});
        w = {rnd(), rnd()};
        gyro_data <= w[47:0];
        temp_data <= w[15:0];
        rate_code <= 8'h5a;
        {gyro_drdy, acc_drdy, temp_drdy, step_det, rate_change} <= 5'h1f;
        @(posedge clk);
        {gyro_drdy, acc_drdy, temp_drdy, step_det, rate_change} <= 5'h00;
        repeat (8) @(posedge clk);
        rd_chk(`FB_ADDR_STAT_LOW, 8'h05, "burst count");
        for (r = 0; r < 5; r++)
            rd_chk(`FB_ADDR_TAG, burst_tags[r], "burst tag");
        rd_chk(`FB_ADDR_STAT_HIGH, stat_hi(0, 1'b0), "drained status");
        chk("stall idle", 8'h01, {7'h00, stall_b});
        complete_run();
    end
endmodule // sensor_batching_fifo_tb

// ===== verilog/batch_fifo_map.vh
// register offsets, field positions, tags and reset values of the batching buffer
`ifndef BATCH_FIFO_MAP_VH
`define BATCH_FIFO_MAP_VH

`define FB_ADDR_EXT_CTRL   7'h06
`define FB_ADDR_WM_LOW     7'h07
`define FB_ADDR_WM_HIGH    7'h08
`define FB_ADDR_RATE       7'h09
`define FB_ADDR_MODE       7'h0a
`define FB_ADDR_PIN_ONE    7'h0d
`define FB_ADDR_PIN_TWO    7'h0e
`define FB_ADDR_STAT_LOW   7'h3a
`define FB_ADDR_STAT_HIGH  7'h3b
`define FB_ADDR_TAG        7'h78
`define FB_ADDR_DATA_FIRST 7'h79
`define FB_ADDR_DATA_LAST  7'h7e

`define FB_CTRL_RESET      8'h00

`define FB_WMH_LEVEL_MSB   0
`define FB_WMH_CFG_EN      4
`define FB_WMH_STOP_WM     7
`define FB_MODE_LSB        0
`define FB_MODE_EXT_SRC    3
`define FB_MODE_TRIG_LSB   4
`define FB_EXT_STEP_EN     4
`define FB_RATE_TS_LSB     6
`define FB_PIN_WM_ROUTE    3
`define FB_PIN_FULL_ROUTE  5

`define FB_ST_WM           7
`define FB_ST_OVR          6
`define FB_ST_FULL         5
`define FB_ST_EMPTY        4

`define FB_MODE_BYPASS     3'h0
`define FB_MODE_STOP       3'h1
`define FB_MODE_CONT_STOP  3'h3
`define FB_MODE_BYP_CONT   3'h4
`define FB_MODE_CONT       3'h6
`define FB_MODE_BYP_STOP   3'h7

`define FB_TAG_GYRO        8'h01
`define FB_TAG_ACC         8'h02
`define FB_TAG_TEMP        8'h03
`define FB_TAG_EXT0        8'h04
`define FB_TAG_STEP        8'h08
`define FB_TAG_TIME        8'h09
`define FB_TAG_CFG         8'h0a

`endif

// ===== verilog/batch_word_mem.v
// word storage of the batching buffer, one write port and one registered read port
module batch_word_mem #(
    parameter WIDTH = 56,
    parameter DEPTH = 512,
    parameter AW = 9
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] wa,
    input wire [WIDTH-1:0] wd,
    input wire [AW-1:0] ra,
    output reg [WIDTH-1:0] rd
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
        rd <= mem[ra];
    end
endmodule // batch_word_mem

// ===== verilog/sensor_batching_fifo.v
// sensor batching buffer: source capture, mode control, storage, status and interrupt pins
// Overview of operation
// - mode 000 keeps the buffer empty and stores nothing.
// - mode 001 appends words and stops storing once full.
// - mode 110 stores continuously, discarding the oldest word when full.
// - mode 011 overwrites while trigger is 0, stops when full while 1.
// - trigger chosen from single tap, double tap, wake-up, free-fall, orientation change.
// - watermark flag set while unread count is at or above watermark level.
// - stop-at-watermark limits usable depth to the watermark level.
// - overrun flag set when an oldest word was overwritten.
// - watermark flag routed to each interrupt pin by its routing bit.
// - full condition routed to each interrupt pin by its full enable.
// - 10-bit unread count split across two status registers.
// - status shows overrun, full, empty, watermark and unread count.
// - capacity is 512 words, 3 kbytes of data.
// - accepts gyro, accel, four external, step, timestamp, temperature words.
// - writes triggered by accel/gyro ready, hub ready or step detection.
// - separate batching rates for accel, gyro and temperature.
// - external words triggered by accel ready or hub ready.
// - step counter stored with timestamp on each detected step.
// - timestamp words decimated by 1, 8 or 32.
// - rate changes store a configuration word with its timestamp.
// - every word carries a tag byte naming its source.
// - mode 100 overwrites while trigger is 1, else acts as bypass.
// - mode 111 stops when full while trigger is 1, else acts as bypass.
// - host reads each word as one tag byte and six data bytes.
`include "batch_fifo_map.vh"

module sensor_batching_fifo #(
    parameter DEPTH = 512,
    parameter AW = 9,
    parameter CW = 10,
    parameter NEXT = 4
) (
    input wire SYS_CLK,
    input wire RST_B,
    input wire [6:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    input wire ACC_DRDY,
    input wire [47:0] ACC_DATA,
    input wire GYRO_DRDY,
    input wire [47:0] GYRO_DATA,
    input wire TEMP_DRDY,
    input wire [15:0] TEMP_DATA,
    input wire HUB_DRDY,
    input wire [NEXT*48-1:0] EXT_DATA,
    input wire STEP_DET,
    input wire [15:0] STEP_COUNT,
    input wire [31:0] TIMESTAMP,
    input wire OUTPUT_RATE_CHANGE,
    input wire [7:0] OUTPUT_RATE_CODE,
    input wire [4:0] TRIGGER_EVENTS,
    output wire SENSOR_STALL_B,
    output wire INTERRUPT_PIN_ONE,
    output wire INTERRUPT_PIN_TWO
);
    localparam NSRC = 10;
    localparam SRC_EXT = 3;
    localparam SRC_STEP = 7;
    localparam SRC_TIME = 8;
    localparam SRC_CFG = 9;
    localparam [CW-1:0] DEPTH_C = DEPTH;
    localparam BEH_BYPASS = 2'd0;
    localparam BEH_STOP = 2'd1;
    localparam BEH_CONT = 2'd2;

    // control registers
    reg [7:0] ext_ctrl;
    reg [7:0] wm_low;
    reg [7:0] wm_high;
    reg [7:0] rate;
    reg [7:0] mode_ctrl;
    reg [7:0] pin_one;
    reg [7:0] pin_two;

    // storage state
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [CW-1:0] unread_word_count;
    reg overrun_flag;
    reg [55:0] word_hold;
    reg [NSRC-1:0] pend;
    reg [1:0] dec_cnt [0:2];
    reg [4:0] ts_cnt;

    wire [8:0] watermark_level = {wm_high[`FB_WMH_LEVEL_MSB], wm_low};
    wire stop_at_watermark = wm_high[`FB_WMH_STOP_WM];
    wire [2:0] mode_sel = mode_ctrl[`FB_MODE_LSB +: 3];
    wire [2:0] trig_sel = mode_ctrl[`FB_MODE_TRIG_LSB +: 3];
    wire trig = (trig_sel < 3'd5) ? TRIGGER_EVENTS[trig_sel] : 1'b0;

    // effective behaviour from the mode field and the selected trigger
    reg [1:0] beh;
    always @* begin
        case (mode_sel)
            `FB_MODE_BYPASS: beh = BEH_BYPASS;
            `FB_MODE_STOP: beh = BEH_STOP;
            `FB_MODE_CONT: beh = BEH_CONT;
            `FB_MODE_CONT_STOP: beh = trig ? BEH_STOP : BEH_CONT;
            `FB_MODE_BYP_CONT: beh = trig ? BEH_CONT : BEH_BYPASS;
            `FB_MODE_BYP_STOP: beh = trig ? BEH_STOP : BEH_BYPASS;
            default: beh = BEH_BYPASS;
        endcase
    end
    wire bypass = (beh == BEH_BYPASS);
    wire cont = (beh == BEH_CONT);

    // flags
    wire [CW-1:0] limit = stop_at_watermark ? {{(CW-9){1'b0}}, watermark_level} : DEPTH_C;
    wire full = (unread_word_count >= limit);
    wire empty = (unread_word_count == {CW{1'b0}});
    wire watermark_flag = (unread_word_count >= {{(CW-9){1'b0}}, watermark_level});

    assign INTERRUPT_PIN_ONE = (pin_one[`FB_PIN_WM_ROUTE] & watermark_flag)
        | (pin_one[`FB_PIN_FULL_ROUTE] & full);
    assign INTERRUPT_PIN_TWO = (pin_two[`FB_PIN_WM_ROUTE] & watermark_flag)
        | (pin_two[`FB_PIN_FULL_ROUTE] & full);

    // batching rate decimation for gyro, accel and temperature
    wire [2:0] drdy = {TEMP_DRDY, ACC_DRDY, GYRO_DRDY};
    wire [2:0] batch;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : rate_div
            wire [1:0] sel = rate[2*g +: 2];
            // 00 off, 01 every sample, 10 every second, 11 every fourth
            assign batch[g] = drdy[g] && (sel != 2'd0)
                && ((sel == 2'd1) || (sel == 2'd2 && !dec_cnt[g][0])
                || (sel == 2'd3 && dec_cnt[g] == 2'd0));
            always @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    dec_cnt[g] <= 2'd0;
                end else if (drdy[g]) begin
                    dec_cnt[g] <= dec_cnt[g] + 2'd1;
                end
            end
        end
    endgenerate

    // timestamp words follow accel/gyro batches, thinned by 1, 8 or 32
    wire [1:0] ts_dec = rate[`FB_RATE_TS_LSB +: 2];
    wire ts_tick = batch[0] | batch[1];
    wire ts_emit = ts_tick && ((ts_dec == 2'd0) || (ts_dec == 2'd1 && ts_cnt[2:0] == 3'd0)
        || (ts_dec == 2'd2 && ts_cnt == 5'd0));
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ts_cnt <= 5'd0;
        end else if (ts_tick) begin
            ts_cnt <= ts_cnt + 5'd1;
        end
    end

    wire ext_trig = mode_ctrl[`FB_MODE_EXT_SRC] ? HUB_DRDY : ACC_DRDY;
    wire rate_wr = REG_WR && (REG_ADDR == `FB_ADDR_RATE);
    wire cfg_evt = wm_high[`FB_WMH_CFG_EN] && (rate_wr || OUTPUT_RATE_CHANGE);

    wire [NSRC-1:0] set;
    assign set[0] = batch[0];
    assign set[1] = batch[1];
    assign set[2] = batch[2];
    assign set[SRC_STEP] = ext_ctrl[`FB_EXT_STEP_EN] & STEP_DET;
    assign set[SRC_TIME] = ts_emit;
    assign set[SRC_CFG] = cfg_evt;

    // one pick per cycle into the buffer; lowest index goes first
    wire buf_in_ready;
    reg [3:0] pick;
    reg pick_valid;
    integer i;
    always @* begin
        pick = 4'd0;
        pick_valid = 1'b0;
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (pend[i]) begin
                pick = i[3:0];
                pick_valid = 1'b1;
            end
        end
    end
    wire grant_any = pick_valid & buf_in_ready & ~bypass;

    generate
        for (g = 0; g < NSRC; g = g + 1) begin : pending
            if (g >= SRC_EXT && g < SRC_EXT + NEXT) begin : ext_src
                assign set[g] = ext_ctrl[g - SRC_EXT] & ext_trig;
            end
            // a new event in the grant cycle keeps the flag set
            always @(posedge SYS_CLK or negedge RST_B) begin
                if (!RST_B) begin
                    pend[g] <= 1'b0;
                end else if (bypass) begin
                    pend[g] <= 1'b0;
                end else begin
                    pend[g] <= set[g] | (pend[g] & ~(grant_any && pick == g));
                end
            end
        end
    endgenerate

    // tagged word for the picked source
    reg [55:0] word_in;
    always @* begin
        case (pick)
            4'd0: word_in = {`FB_TAG_GYRO, GYRO_DATA};
            4'd1: word_in = {`FB_TAG_ACC, ACC_DATA};
            4'd2: word_in = {`FB_TAG_TEMP, 32'h0000_0000, TEMP_DATA};
            4'd3, 4'd4, 4'd5, 4'd6:
                word_in = {`FB_TAG_EXT0 + {4'h0, pick - 4'd3}, EXT_DATA[(pick - 4'd3) * 48 +: 48]};
            4'd7: word_in = {`FB_TAG_STEP, STEP_COUNT, TIMESTAMP};
            4'd8: word_in = {`FB_TAG_TIME, 16'h0000, TIMESTAMP};
            4'd9: word_in = {`FB_TAG_CFG, OUTPUT_RATE_CODE, rate, TIMESTAMP};
            default: word_in = 56'h00_0000_0000_0000;
        endcase
    end

    // a host pop and a store never share a cycle; the buffer absorbs the stall
    wire tag_rd = REG_RD && (REG_ADDR == `FB_ADDR_TAG);
    wire pop = tag_rd && !empty && !bypass;
    wire buf_out_valid;
    wire [55:0] buf_out_data;
    wire store_take = buf_out_valid & ~pop;
    wire wr_ok = store_take && !bypass && (!full || cont);
    wire drop_old = wr_ok && full && cont;

    assign SENSOR_STALL_B = buf_in_ready;

    two_entry_buffer #(
        .W(56)
    ) u_buf (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .in_valid(grant_any),
        .in_ready(buf_in_ready),
        .in_data(word_in),
        .out_valid(buf_out_valid),
        .out_ready(~pop),
        .out_data(buf_out_data)
    );

    wire [55:0] mem_rd;
    batch_word_mem #(
        .WIDTH(56),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .clk(SYS_CLK),
        .we(wr_ok),
        .wa(wr_ptr),
        .wd(buf_out_data),
        .ra(rd_ptr),
        .rd(mem_rd)
    );

    wire stat_high_rd = REG_RD && (REG_ADDR == `FB_ADDR_STAT_HIGH);

    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            unread_word_count <= {CW{1'b0}};
            overrun_flag <= 1'b0;
        end else if (bypass) begin
            // leaving contents behind is the host's way to restart stop-when-full
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            unread_word_count <= {CW{1'b0}};
            overrun_flag <= 1'b0;
        end else begin
            if (wr_ok) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop || drop_old) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (wr_ok && !full) begin
                unread_word_count <= unread_word_count + {{(CW-1){1'b0}}, 1'b1};
            end else if (pop) begin
                unread_word_count <= unread_word_count - {{(CW-1){1'b0}}, 1'b1};
            end
            if (drop_old) begin
                overrun_flag <= 1'b1;
            end else if (stat_high_rd) begin
                overrun_flag <= 1'b0;
            end
        end
    end

    // control register writes
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ext_ctrl <= `FB_CTRL_RESET;
            wm_low <= `FB_CTRL_RESET;
            wm_high <= `FB_CTRL_RESET;
            rate <= `FB_CTRL_RESET;
            mode_ctrl <= `FB_CTRL_RESET;
            pin_one <= `FB_CTRL_RESET;
            pin_two <= `FB_CTRL_RESET;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `FB_ADDR_EXT_CTRL: ext_ctrl <= REG_WDATA;
                `FB_ADDR_WM_LOW: wm_low <= REG_WDATA;
                `FB_ADDR_WM_HIGH: wm_high <= REG_WDATA;
                `FB_ADDR_RATE: rate <= REG_WDATA;
                `FB_ADDR_MODE: mode_ctrl <= REG_WDATA;
                `FB_ADDR_PIN_ONE: pin_one <= REG_WDATA;
                `FB_ADDR_PIN_TWO: pin_two <= REG_WDATA;
                default: ext_ctrl <= ext_ctrl;
            endcase
        end
    end

    // register reads answer one cycle after the strobe
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
            word_hold <= 56'h00_0000_0000_0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `FB_ADDR_EXT_CTRL: REG_RDATA <= ext_ctrl;
                `FB_ADDR_WM_LOW: REG_RDATA <= wm_low;
                `FB_ADDR_WM_HIGH: REG_RDATA <= wm_high;
                `FB_ADDR_RATE: REG_RDATA <= rate;
                `FB_ADDR_MODE: REG_RDATA <= mode_ctrl;
                `FB_ADDR_PIN_ONE: REG_RDATA <= pin_one;
                `FB_ADDR_PIN_TWO: REG_RDATA <= pin_two;
                `FB_ADDR_STAT_LOW: REG_RDATA <= unread_word_count[7:0];
                `FB_ADDR_STAT_HIGH: REG_RDATA <= {watermark_flag, overrun_flag, full, empty,
                    2'b00, unread_word_count[9:8]};
                `FB_ADDR_TAG: begin
                    // the whole word is latched so its data bytes stay stable
                    if (pop) begin
                        REG_RDATA <= mem_rd[55:48];
                        word_hold <= mem_rd;
                    end else begin
                        REG_RDATA <= 8'h00;
                    end
                end
                default: begin
                    if (REG_ADDR >= `FB_ADDR_DATA_FIRST && REG_ADDR <= `FB_ADDR_DATA_LAST) begin
                        REG_RDATA <= word_hold[(REG_ADDR - `FB_ADDR_DATA_FIRST) * 8 +: 8];
                    end else begin
                        REG_RDATA <= 8'h00;
                    end
                end
            endcase
        end
    end
endmodule // sensor_batching_fifo

// ===== verilog/two_entry_buffer.v
// two-entry valid/ready buffer in front of the word storage
module two_entry_buffer #(
    parameter W = 56
) (
    input wire clk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] head;
    reg [W-1:0] tail;
    reg [1:0] fill;
    wire push = in_valid & in_ready;
    wire pull = out_valid & out_ready;

    assign in_ready = (fill != 2'd2);
    assign out_valid = (fill != 2'd0);
    assign out_data = head;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            head <= {W{1'b0}};
            tail <= {W{1'b0}};
            fill <= 2'd0;
        end else if (push && pull) begin
            if (fill == 2'd1) begin
                head <= in_data;
            end else begin
                head <= tail;
                tail <= in_data;
            end
        end else if (push) begin
            if (fill == 2'd0) begin
                head <= in_data;
            end else begin
                tail <= in_data;
            end
            fill <= fill + 2'd1;
        end else if (pull) begin
            head <= tail;
            fill <= fill - 2'd1;
        end
    end
endmodule // two_entry_buffer
